// >>> src/mseq_pkg.sv
// Constants and types shared by the MAC microsequencer and its cipher control unit.
// Assumes a single 250 MHz clock domain and no software-visible registers.
package mseq_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W   = 16;
  localparam int PC_W     = 10;
  localparam int INSN_W   = 48;
  localparam int SHM_AW   = 10;
  localparam int IHR_AW   = 8;
  localparam int SPAD_AW  = 6;
  localparam int COND_W   = 32;
  localparam int STACK_D  = 8;
  localparam int KEY_W    = 128;
  localparam int KIDX_W   = 5;

  // ----------------------------------------------------------------
  // Instruction field positions (low bit of each field)
  // ----------------------------------------------------------------
  localparam int F_OPC_LO  = 44;  // 4-bit opcode
  localparam int F_SRCA_LO = 42;  // 2-bit operand A source
  localparam int F_SRCB_LO = 40;  // 2-bit operand B source
  localparam int F_DST_LO  = 38;  // 2-bit destination
  localparam int F_ALU_LO  = 35;  // 3-bit alu function
  localparam int F_CSEL_LO = 30;  // 5-bit condition select
  localparam int F_CPOL    = 29;  // condition polarity
  localparam int F_AA_LO   = 16;  // 10-bit operand A address / target
  localparam int F_LIT_LO  = 0;   // 16-bit literal / operand B address

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [9:0]  PC_RST    = 10'h000;
  localparam logic [15:0] DATA_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // Opcodes, operand sources, destinations, alu functions
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ALU  = 4'h0,  // alu, write result
    OP_JMP  = 4'h1,  // unconditional jump to literal
    OP_BRC  = 4'h2,  // branch on hardware condition
    OP_BRZ  = 4'h3,  // branch if alu result is zero
    OP_BRNZ = 4'h4,  // branch if alu result non-zero
    OP_CALL = 4'h5,
    OP_RET  = 4'h6,
    OP_CIPH = 4'h7   // launch cipher for a frame
  } mseq_op_t;

  typedef enum logic [1:0] {
    SRC_SHM = 2'h0, SRC_SPAD = 2'h1, SRC_IHR = 2'h2, SRC_LIT = 2'h3
  } mseq_src_t;

  typedef enum logic [1:0] {
    DST_SHM = 2'h0, DST_SPAD = 2'h1, DST_IHR = 2'h2, DST_NONE = 2'h3
  } mseq_dst_t;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0, ALU_SUB = 3'h1, ALU_AND = 3'h2, ALU_OR = 3'h3,
    ALU_XOR = 3'h4, ALU_MOV = 3'h5, ALU_SHL = 3'h6, ALU_SHR = 3'h7
  } mseq_alu_t;

  // Cipher algorithm codes
  typedef enum logic [1:0] {
    CIPH_NONE = 2'h0, CIPH_WEP = 2'h1, CIPH_TKIP = 2'h2, CIPH_CCMP = 2'h3
  } mseq_ciph_t;

  // Association security kinds held per association
  localparam logic [1:0] ASSOC_OPEN = 2'h0;
  localparam logic [1:0] ASSOC_WEP  = 2'h1;
  localparam logic [1:0] ASSOC_WPA  = 2'h2;
  localparam logic [1:0] ASSOC_RSN  = 2'h3;

  // Frame types (2-bit type field)
  localparam logic [1:0] FTYPE_MGMT = 2'h0;
  localparam logic [1:0] FTYPE_CTRL = 2'h1;
  localparam logic [1:0] FTYPE_DATA = 2'h2;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_FETCH = 4'b0001,
    ST_EXEC  = 4'b0010,
    ST_WAIT  = 4'b0100,
    ST_CIPH  = 4'b1000
  } mseq_state_t;

endpackage : mseq_pkg

// >>> src/mseq_cipher_ctrl.sv
// Cipher selection and key delivery toward the cipher engine.
// Assumes the cipher engine pairs with the transmit and receive engines on its own.
`timescale 1ns/100ps
module mseq_cipher_ctrl
  import mseq_pkg::*;
#(
  parameter int KEYS = 32
) (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              start_i,
  input  wire logic [1:0]        frame_type_i,
  input  wire logic              frame_prot_i,
  input  wire logic              dir_rx_i,
  input  wire logic [1:0]        assoc_sec_i,
  input  wire logic [KIDX_W-1:0] key_idx_i,
  input  wire logic              key_we_i,
  input  wire logic [KIDX_W-1:0] key_waddr_i,
  input  wire logic [KEY_W-1:0]  key_wdata_i,
  output logic                   cipher_start_o,
  output logic [1:0]             cipher_alg_o,
  output logic                   cipher_dir_rx_o,
  output logic [KEY_W-1:0]       cipher_key_o
);

  // ----------------------------------------------------------------
  // On-chip key table
  // ----------------------------------------------------------------
  logic [KEY_W-1:0] key_tab_q [KEYS];

  // Plain array, no reset, so it maps onto memory
  always_ff @(posedge clk_i) begin
    if (key_we_i) begin
      key_tab_q[key_waddr_i] <= key_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Algorithm choice and launch
  // ----------------------------------------------------------------
  logic [1:0]       alg_d, alg_q;
  logic             go_d, go_q, dir_d, dir_q;
  logic [KEY_W-1:0] key_d, key_q;

  // Control frames never carry a protected body
  always_comb begin
    alg_d = CIPH_NONE;
    if (frame_prot_i && frame_type_i != FTYPE_CTRL) begin
      case (assoc_sec_i)
        ASSOC_WEP: alg_d = CIPH_WEP;
        ASSOC_WPA: alg_d = CIPH_TKIP;
        ASSOC_RSN: alg_d = CIPH_CCMP;
        default:   alg_d = CIPH_NONE;
      endcase
    end
    go_d  = start_i;
    dir_d = start_i ? dir_rx_i : dir_q;
    key_d = start_i ? key_tab_q[key_idx_i] : key_q;
    if (!start_i) begin
      alg_d = alg_q;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alg_q <= CIPH_NONE;
      go_q  <= 1'b0;
      dir_q <= 1'b0;
      key_q <= '0;
    end else begin
      alg_q <= alg_d;
      go_q  <= go_d;
      dir_q <= dir_d;
      key_q <= key_d;
    end
  end

  // Engine handles CIPHER_ENGINE, TKIP and CCMP; direction picks tx or rx pairing
  assign cipher_start_o  = go_q;
  assign cipher_alg_o    = alg_q;
  assign cipher_dir_rx_o = dir_q;
  assign cipher_key_o    = key_q;

endmodule : mseq_cipher_ctrl

// >>> src/mseq_core.sv
// MAC microsequencer: fetch, operand read, alu, write-back, branch and cipher launch.
// Assumes synchronous memories with one-cycle read latency and an internal register
// bus that answers with a ready pulse.
//
// Functional notes
// - Fetch address from program counter, instruction literal or return stack.
// - Alu operands from shared memory, scratch pad, internal register or literal.
// - Alu result goes to shared memory, scratch pad or internal register.
// - Two branch forms: hardware conditional and alu-result branch.
// - Condition signals tested directly, no internal register read needed.
// - Shared memory is operand source, store and host exchange point.
// - Local scratch pad holds temporary variables, apart from shared memory.
// - Internal registers reached over a dedicated register bus.
// - Cipher chosen from frame type and association security.
// - Keys for protected frames come from on-chip key table.
// - Cipher engine does CIPHER_ENGINE, TKIP, CCMP encrypt, decrypt and MIC.
// - Cipher engine pairs with transmit engine and receive engine.
`timescale 1ns/100ps
module mseq_core
  import mseq_pkg::*;
#(
  parameter int SPAD_WORDS = 64
) (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  // Microcode memory
  output logic [PC_W-1:0]        ucode_addr_o,
  input  wire logic [INSN_W-1:0] ucode_data_i,
  // Shared memory port
  output logic                   shm_en_o,
  output logic                   shm_we_o,
  output logic [SHM_AW-1:0]      shm_addr_o,
  output logic [DATA_W-1:0]      shm_wdata_o,
  input  wire logic [DATA_W-1:0] shm_rdata_i,
  // Internal register bus
  output logic                   ihr_req_o,
  output logic                   ihr_we_o,
  output logic [IHR_AW-1:0]      ihr_addr_o,
  output logic [DATA_W-1:0]      ihr_wdata_o,
  input  wire logic              ihr_ready_i,
  input  wire logic [DATA_W-1:0] ihr_rdata_i,
  // Branch condition signals from the engines
  input  wire logic [COND_W-1:0] cond_i,
  // Cipher engine side
  input  wire logic [1:0]        frame_type_i,
  input  wire logic              frame_prot_i,
  input  wire logic [1:0]        assoc_sec_i,
  input  wire logic              key_we_i,
  input  wire logic [KIDX_W-1:0] key_waddr_i,
  input  wire logic [KEY_W-1:0]  key_wdata_i,
  output logic                   cipher_start_o,
  output logic [1:0]             cipher_alg_o,
  output logic                   cipher_dir_rx_o,
  output logic [KEY_W-1:0]       cipher_key_o
);

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  mseq_state_t       st_d, st_q;
  logic [PC_W-1:0]   pc_d, pc_q;
  logic [INSN_W-1:0] ir_d, ir_q;

  logic [3:0]        opc;
  logic [1:0]        srca, srcb, dst;
  logic [2:0]        afn;
  logic [4:0]        csel;
  logic              cpol;
  logic [9:0]        aaddr;
  logic [15:0]       lit;

  // Fields of the held instruction
  assign opc   = ir_q[F_OPC_LO+:4];
  assign srca  = ir_q[F_SRCA_LO+:2];
  assign srcb  = ir_q[F_SRCB_LO+:2];
  assign dst   = ir_q[F_DST_LO+:2];
  assign afn   = ir_q[F_ALU_LO+:3];
  assign csel  = ir_q[F_CSEL_LO+:5];
  assign cpol  = ir_q[F_CPOL];
  assign aaddr = ir_q[F_AA_LO+:10];
  assign lit   = ir_q[F_LIT_LO+:16];

  // ----------------------------------------------------------------
  // Scratch pad and return stack
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] spad_q [SPAD_WORDS];
  logic [PC_W-1:0]   stk_q  [STACK_D];
  logic [2:0]        sp_d, sp_q;

  // ----------------------------------------------------------------
  // Operand read
  // ----------------------------------------------------------------
  // Operand A from a slow source is fetched first; B is literal or scratch pad,
  // so only one shared or bus read is ever outstanding.
  logic [DATA_W-1:0] opa, opb, res;
  logic [DATA_W-1:0] ihr_dat_d, ihr_dat_q;

  always_comb begin
    case (srca)
      SRC_SHM:  opa = shm_rdata_i;
      SRC_SPAD: opa = spad_q[aaddr[SPAD_AW-1:0]];
      SRC_IHR:  opa = ihr_dat_q;
      default:  opa = lit;
    endcase
    opb = (srcb == SRC_SPAD) ? spad_q[lit[SPAD_AW-1:0]] : lit;
  end

  // Alu
  always_comb begin
    case (afn)
      ALU_ADD: res = opa + opb;
      ALU_SUB: res = opa - opb;
      ALU_AND: res = opa & opb;
      ALU_OR:  res = opa | opb;
      ALU_XOR: res = opa ^ opb;
      ALU_MOV: res = opa;
      ALU_SHL: res = opa << opb[3:0];
      default: res = opa >> opb[3:0];
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  logic cond_hit, zero, need_rd, wr_spad, ciph_go;

  assign cond_hit = cond_i[csel] ^ cpol;
  assign zero     = (res == DATA_RST);
  assign need_rd  = (opc == OP_ALU || opc == OP_BRZ || opc == OP_BRNZ) &&
                    (srca == SRC_SHM || srca == SRC_IHR);

  // Next state, program counter and stack pointer
  always_comb begin
    st_d      = st_q;
    pc_d      = pc_q;
    ir_d      = ir_q;
    sp_d      = sp_q;
    ihr_dat_d = ihr_dat_q;
    wr_spad   = 1'b0;
    ciph_go   = 1'b0;
    case (st_q)
      ST_FETCH: begin
        ir_d = ucode_data_i;
        st_d = ST_EXEC;
      end
      ST_EXEC: begin
        if (need_rd && srca == SRC_IHR && !ihr_ready_i) begin
          st_d = ST_EXEC;                                // Hold until bus answers
        end else if (need_rd && srca == SRC_SHM) begin
          st_d = ST_WAIT;                                // One-cycle memory read
        end else begin
          if (srca == SRC_IHR) begin
            ihr_dat_d = ihr_rdata_i;
          end
          st_d = need_rd ? ST_WAIT : ST_FETCH;
          pc_d = pc_q + 10'h001;
          case (opc)
            OP_JMP:  pc_d = lit[PC_W-1:0];
            OP_BRC:  if (cond_hit) pc_d = lit[PC_W-1:0];
            OP_BRZ:  if (zero) pc_d = lit[PC_W-1:0];
            OP_BRNZ: if (!zero) pc_d = lit[PC_W-1:0];
            OP_CALL: begin
              pc_d = lit[PC_W-1:0];
              sp_d = sp_q + 3'h1;
            end
            OP_RET: begin
              pc_d = stk_q[sp_q - 3'h1];
              sp_d = sp_q - 3'h1;
            end
            OP_CIPH: begin
              ciph_go = 1'b1;
              st_d    = ST_CIPH;
            end
            default: begin
            end
          endcase
          if (need_rd) begin
            pc_d = pc_q;                                 // Step after operand is in
          end else if (opc == OP_ALU) begin
            wr_spad = (dst == DST_SPAD);
          end
        end
      end
      ST_WAIT: begin
        st_d    = ST_FETCH;
        pc_d    = pc_q + 10'h001;
        wr_spad = (opc == OP_ALU) && (dst == DST_SPAD);
        if ((opc == OP_BRZ && zero) || (opc == OP_BRNZ && !zero)) begin
          pc_d = lit[PC_W-1:0];
        end
      end
      ST_CIPH: st_d = ST_FETCH;                          // Key lookup settles
      default: st_d = ST_FETCH;
    endcase
  end

  // Next address goes out, so the one-cycle ROM read is ready at the fetch edge
  assign ucode_addr_o = pc_d;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q      <= ST_FETCH;
      pc_q      <= PC_RST;
      ir_q      <= '0;
      sp_q      <= 3'h0;
      ihr_dat_q <= DATA_RST;
    end else begin
      st_q      <= st_d;
      pc_q      <= pc_d;
      ir_q      <= ir_d;
      sp_q      <= sp_d;
      ihr_dat_q <= ihr_dat_d;
    end
  end

  // Scratch pad and stack are plain arrays, written without reset
  always_ff @(posedge clk_i) begin
    if (wr_spad) begin
      spad_q[aaddr[SPAD_AW-1:0]] <= res;
    end
    if (st_q == ST_EXEC && opc == OP_CALL) begin
      stk_q[sp_q] <= pc_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Shared memory and internal register bus
  // ----------------------------------------------------------------
  logic alu_wr, in_exec, in_wait;

  assign in_exec = (st_q == ST_EXEC);
  assign in_wait = (st_q == ST_WAIT);
  assign alu_wr  = (opc == OP_ALU) && ((in_exec && !need_rd) || in_wait);

  // Reads issue in exec; writes in the cycle the result is final
  assign shm_en_o    = (in_exec && need_rd && srca == SRC_SHM) || (alu_wr && dst == DST_SHM);
  assign shm_we_o    = alu_wr && (dst == DST_SHM);
  assign shm_addr_o  = aaddr[SHM_AW-1:0];
  assign shm_wdata_o = res;

  // Bus request held until ready; writes complete without waiting
  assign ihr_req_o   = (in_exec && need_rd && srca == SRC_IHR) || (alu_wr && dst == DST_IHR);
  assign ihr_we_o    = alu_wr && (dst == DST_IHR);
  assign ihr_addr_o  = aaddr[IHR_AW-1:0];
  assign ihr_wdata_o = res;

  // ----------------------------------------------------------------
  // Cipher control
  // ----------------------------------------------------------------
  mseq_cipher_ctrl u_ciph (
    .clk_i           (clk_i),
    .arst_n_i        (arst_n_i),
    .start_i         (ciph_go),
    .frame_type_i    (frame_type_i),
    .frame_prot_i    (frame_prot_i),
    .dir_rx_i        (lit[8]),
    .assoc_sec_i     (assoc_sec_i),
    .key_idx_i       (lit[KIDX_W-1:0]),
    .key_we_i        (key_we_i),
    .key_waddr_i     (key_waddr_i),
    .key_wdata_i     (key_wdata_i),
    .cipher_start_o  (cipher_start_o),
    .cipher_alg_o    (cipher_alg_o),
    .cipher_dir_rx_o (cipher_dir_rx_o),
    .cipher_key_o    (cipher_key_o)
  );

endmodule : mseq_core

// >>> bench/mseq_core_props.sv
// Assertion checker for the microsequencer core, bound to every instance.
// Sees only the core's ports; one clock, asynchronous active-low reset.
`timescale 1ns/100ps
module mseq_core_chk
  import mseq_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              arst_n_i,
  input wire logic [PC_W-1:0]   ucode_addr_o,
  input wire logic              shm_en_o,
  input wire logic              shm_we_o,
  input wire logic              ihr_req_o,
  input wire logic              ihr_we_o,
  input wire logic [IHR_AW-1:0] ihr_addr_o,
  input wire logic              ihr_ready_i,
  input wire logic [1:0]        frame_type_i,
  input wire logic              frame_prot_i,
  input wire logic              cipher_start_o,
  input wire logic [1:0]        cipher_alg_o,
  input wire logic              cipher_dir_rx_o,
  input wire logic [KEY_W-1:0]  cipher_key_o
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // Register bus read: waiting, then answered
  sequence s_rd_wait; ihr_req_o && !ihr_we_o && !ihr_ready_i; endsequence
  sequence s_rd_ans; ihr_req_o && !ihr_we_o && ihr_ready_i; endsequence

  a_reset_quiet: assert property (disable iff (1'b0) !arst_n_i |-> ucode_addr_o == PC_RST && !ihr_req_o)
    else $error("core active during reset");
  a_fetch_pace: assert property ($changed(ucode_addr_o) |=> $stable(ucode_addr_o))
    else $error("fetch address moved two cycles running");
  a_ihr_rd_hold: assert property (s_rd_wait |=> ihr_req_o && !ihr_we_o && $stable(ihr_addr_o))
    else $error("register read dropped before ready");
  a_ihr_rd_done: assert property (s_rd_ans |=> !(ihr_req_o && !ihr_we_o))
    else $error("register read held after answer");
  a_ihr_wr_pulse: assert property (ihr_req_o && ihr_we_o |=> !ihr_we_o)
    else $error("register write longer than one cycle");
  a_shm_wr_pulse: assert property (shm_we_o |-> shm_en_o ##1 !shm_we_o)
    else $error("shared memory write malformed");
  a_start_pulse: assert property (cipher_start_o |=> !cipher_start_o)
    else $error("cipher start not a pulse");
  a_ciph_hold: assert property (!cipher_start_o |-> $stable(cipher_alg_o) && $stable(cipher_key_o) && $stable(cipher_dir_rx_o))
    else $error("cipher outputs changed without start");
  a_unprot_none: assert property (cipher_start_o && !$past(frame_prot_i) && !$past(frame_prot_i, 2) && !$past(frame_prot_i, 3) |-> cipher_alg_o == CIPH_NONE)
    else $error("unprotected frame given a cipher");
  a_ctrl_none: assert property (cipher_start_o && $past(frame_type_i) == FTYPE_CTRL && $past(frame_type_i, 2) == FTYPE_CTRL && $past(frame_type_i, 3) == FTYPE_CTRL |-> cipher_alg_o == CIPH_NONE)
    else $error("control frame given a cipher");
endmodule : mseq_core_chk

bind mseq_core mseq_core_chk u_chk (.clk_i, .arst_n_i, .ucode_addr_o, .shm_en_o, .shm_we_o, .ihr_req_o, .ihr_we_o,
  .ihr_addr_o, .ihr_ready_i, .frame_type_i, .frame_prot_i, .cipher_start_o, .cipher_alg_o, .cipher_dir_rx_o, .cipher_key_o);

// >>> bench/mseq_mem_model.sv
// Far-side model: microcode ROM, shared memory and register bus engines.
// Assumes the core's single clock; bench loads the ROM array directly.
`timescale 1ns/100ps
module mseq_mem_model
  import mseq_pkg::*;
#(
  parameter int DLY = 3
) (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic [PC_W-1:0]   ucode_addr_i,
  output logic [INSN_W-1:0]      ucode_data_o,
  input  wire logic              shm_en_i,
  input  wire logic              shm_we_i,
  input  wire logic [SHM_AW-1:0] shm_addr_i,
  input  wire logic [DATA_W-1:0] shm_wdata_i,
  output logic [DATA_W-1:0]      shm_rdata_o,
  input  wire logic              ihr_req_i,
  input  wire logic              ihr_we_i,
  input  wire logic [IHR_AW-1:0] ihr_addr_i,
  input  wire logic [DATA_W-1:0] ihr_wdata_i,
  output logic                   ihr_ready_o,
  output logic [DATA_W-1:0]      ihr_rdata_o
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [INSN_W-1:0] rom    [1024];
  logic [DATA_W-1:0] shared_memory_bus    [1024];
  logic [DATA_W-1:0] ihr_wr [256];
  logic [3:0]        cnt_q;

  // Memories keep no reset, like the real arrays
  always_ff @(posedge clk_i) begin
    ucode_data_o <= rom[ucode_addr_i];
    if (shm_en_i && shm_we_i) shared_memory_bus[shm_addr_i] <= shm_wdata_i;
    if (ihr_req_i && ihr_we_i) ihr_wr[ihr_addr_i] <= ihr_wdata_i;
  end

  // Answers; idle data toggles so stale values never pass
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shm_rdata_o <= '0;
      ihr_rdata_o <= '0;
      ihr_ready_o <= 1'b0;
      cnt_q       <= '0;
    end else begin
      shm_rdata_o <= (shm_en_i && !shm_we_i) ? shared_memory_bus[shm_addr_i] : ~shm_rdata_o;
      ihr_ready_o <= 1'b0;
      ihr_rdata_o <= ~ihr_rdata_o;
      if (ihr_req_i && !ihr_we_i && !ihr_ready_o) begin
        if (cnt_q == 4'(DLY)) begin
          ihr_ready_o <= 1'b1;
          ihr_rdata_o <= {8'ha5, ihr_addr_i};
          cnt_q       <= '0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule : mseq_mem_model

// >>> bench/mac_microsequencer_cipher_ctrl_tb_top.sv
// Self-checking bench for the microsequencer core with a slow register bus.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module mac_microsequencer_cipher_ctrl_tb_top
  import mseq_pkg::*;
;
  logic              clk_i = 1'b0;
  logic              arst_n_i = 1'b1;
  logic [COND_W-1:0] cond_i = 32'h0000_0020;
  logic [1:0]        frame_type_i = FTYPE_DATA;
  logic [1:0]        assoc_sec_i = ASSOC_RSN;
  logic              frame_prot_i = 1'b1;
  logic              key_we_i = 1'b0;
  logic [KIDX_W-1:0] key_waddr_i = '0;
  logic [KEY_W-1:0]  key_wdata_i = '0;
  logic [PC_W-1:0]   ucode_addr;
  logic [INSN_W-1:0] ucode_data;
  logic              shm_en, shm_we, ihr_req, ihr_we, ihr_rdy, c_start, c_rx;
  logic [SHM_AW-1:0] shm_addr;
  logic [IHR_AW-1:0] ihr_addr;
  logic [DATA_W-1:0] shm_wd, shm_rd, ihr_wd, ihr_rd;
  logic [1:0]        c_alg;
  logic [KEY_W-1:0]  c_key;
  int                bad_count = 0;
  int                total_checks = 0;

  always #2 clk_i = ~clk_i;

  mseq_core dut (.clk_i, .arst_n_i, .ucode_addr_o(ucode_addr), .ucode_data_i(ucode_data), .shm_en_o(shm_en),
    .shm_we_o(shm_we), .shm_addr_o(shm_addr), .shm_wdata_o(shm_wd), .shm_rdata_i(shm_rd), .ihr_req_o(ihr_req),
    .ihr_we_o(ihr_we), .ihr_addr_o(ihr_addr), .ihr_wdata_o(ihr_wd), .ihr_ready_i(ihr_rdy), .ihr_rdata_i(ihr_rd),
    .cond_i, .frame_type_i, .frame_prot_i, .assoc_sec_i, .key_we_i, .key_waddr_i, .key_wdata_i,
    .cipher_start_o(c_start), .cipher_alg_o(c_alg), .cipher_dir_rx_o(c_rx), .cipher_key_o(c_key));

  mseq_mem_model #(.DLY(3)) pm (.clk_i, .arst_n_i, .ucode_addr_i(ucode_addr), .ucode_data_o(ucode_data),
    .shm_en_i(shm_en), .shm_we_i(shm_we), .shm_addr_i(shm_addr), .shm_wdata_i(shm_wd), .shm_rdata_o(shm_rd),
    .ihr_req_i(ihr_req), .ihr_we_i(ihr_we), .ihr_addr_i(ihr_addr), .ihr_wdata_i(ihr_wd), .ihr_ready_o(ihr_rdy),
    .ihr_rdata_o(ihr_rd));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [KEY_W-1:0] seen, input logic [KEY_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [INSN_W-1:0] mk(input logic [3:0] op, input logic [1:0] sa, input logic [1:0] ds,
                                            input logic [2:0] al, input logic [4:0] cs, input logic pl,
                                            input logic [9:0] aa, input logic [15:0] lt);
    return {op, sa, SRC_LIT, ds, al, cs, pl, 3'h0, aa, lt};
  endfunction : mk

  // Branch-type word: no write-back, literal operands
  function automatic logic [INSN_W-1:0] br(input logic [3:0] op, input logic [4:0] cs, input logic pl,
                                            input logic [15:0] lt);
    return mk(op, SRC_LIT, DST_NONE, ALU_XOR, cs, pl, 10'h000, lt);
  endfunction : br

  // Bounded wait for one launch pulse, sampled mid-cycle
  task automatic wait_start;
    for (int n = 0; n < 100; n++) begin
      @(negedge clk_i);
      if (c_start === 1'b1) return;
    end
    chk("cipher start seen", 0, 1);
  endtask : wait_start

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Program: every source and sink, each branch form, call and return
  task automatic t_load;
    for (int i = 0; i < 1024; i++) pm.rom[i] = mk(OP_ALU, SRC_LIT, DST_SHM, ALU_MOV, 0, 0, 10'h3ff, 16'hdead);
    pm.rom[0]     = mk(OP_ALU, SRC_LIT, DST_SHM, ALU_ADD, 0, 0, 10'h010, 16'h1234);
    pm.rom[1]     = mk(OP_ALU, SRC_SHM, DST_SPAD, ALU_SUB, 0, 0, 10'h010, 16'h0001);
    pm.rom[2]     = mk(OP_ALU, SRC_SPAD, DST_IHR, ALU_OR, 0, 0, 10'h010, 16'h0000);
    pm.rom[3]     = mk(OP_ALU, SRC_IHR, DST_SHM, ALU_AND, 0, 0, 10'h022, 16'h00ff);
    pm.rom[4]     = br(OP_BRC, 5'd5, 1'b0, 16'h0020);
    pm.rom[10'h20] = br(OP_BRC, 5'd6, 1'b1, 16'h0024);
    pm.rom[10'h24] = br(OP_BRC, 5'd5, 1'b1, 16'h0030);
    pm.rom[10'h25] = br(OP_BRNZ, 5'd0, 1'b0, 16'h0030);
    pm.rom[10'h26] = br(OP_BRZ, 5'd0, 1'b0, 16'h0028);
    pm.rom[10'h28] = mk(OP_BRNZ, SRC_LIT, DST_NONE, ALU_ADD, 0, 0, 10'h000, 16'h0040);
    pm.rom[10'h40] = br(OP_CALL, 5'd0, 1'b0, 16'h0050);
    pm.rom[10'h50] = mk(OP_ALU, SRC_LIT, DST_IHR, ALU_MOV, 0, 0, 10'h033, 16'h0bee);
    pm.rom[10'h51] = br(OP_RET, 5'd0, 1'b0, 16'h0000);
    pm.rom[10'h41] = br(OP_CIPH, 5'd0, 1'b0, 16'h0103);
    pm.rom[10'h42] = br(OP_JMP, 5'd0, 1'b0, 16'h0041);
  endtask : t_load

  task automatic t_reset;
    arst_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk("pc in reset", ucode_addr, PC_RST);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    key_we_i    <= 1'b1;
    key_waddr_i <= 5'd3;
    key_wdata_i <= {16{8'h33}};
    @(posedge clk_i);
    key_waddr_i <= 5'd7;
    key_wdata_i <= {16{8'h77}};
    @(posedge clk_i);
    key_we_i    <= 1'b0;
  endtask : t_reset

  // Flow reaches the launch only along the intended path
  task automatic t_flow;
    wait_start();
    chk("shm add", pm.shared_memory_bus[10'h010], 16'h2468);
    chk("spad to reg", pm.ihr_wr[8'h10], 16'h2467);
    chk("reg read", pm.shared_memory_bus[10'h022], 16'h0022);
    chk("call body", pm.ihr_wr[8'h33], 16'h0bee);
    chk("no stray", pm.shared_memory_bus[10'h3ff] === 16'hdead, 0);
    chk("first alg", c_alg, CIPH_CCMP);
    chk("first dir", c_rx, 1'b1);
  endtask : t_flow

  // Cipher table by frame type, protection and association
  task automatic t_cipher;
    logic [6:0] tbl [7] = '{7'b10_1_00_00, 7'b10_1_01_01, 7'b10_1_10_10, 7'b10_1_11_11,
                            7'b01_1_11_00, 7'b10_0_11_00, 7'b00_1_11_11};
    foreach (tbl[i]) begin
      @(posedge clk_i);
      frame_type_i <= tbl[i][6:5];
      frame_prot_i <= tbl[i][4];
      assoc_sec_i  <= tbl[i][3:2];
      wait_start();
      wait_start();
      chk("alg", c_alg, tbl[i][1:0]);
    end
    chk("key 3", c_key, {16{8'h33}});
    pm.rom[10'h41] = br(OP_CIPH, 5'd0, 1'b0, 16'h0007);
    wait_start();
    wait_start();
    chk("key 7", c_key, {16{8'h77}});
    chk("tx dir", c_rx, 1'b0);
  endtask : t_cipher

  initial begin
    t_load();
    t_reset();
    t_flow();
    t_cipher();
    wrap_up();
  end

  // Watchdog: whole run needs well under 1000 cycles
  initial begin
    repeat (4000) @(posedge clk_i);
    bad_count++;
    wrap_up();
  end
endmodule : mac_microsequencer_cipher_ctrl_tb_top
